/* File: design/secl_loader.sv */
// Serial EEPROM configuration loader and software two-wire master
// How it works
// - After reset, if the serial bus is present, fetch defaults from the EEPROM.
// - EEPROM byte 00h is the load flag: 01h loads, FFh does not.
// - Byte 01h loads command bits 8, 6-5, 2-0; bit 8 from bit 7.
// - Bytes 02h/03h form the subsystem vendor identity, low byte first.
// - Bytes 04h/05h form the subsystem identity, low byte first.
// - Bytes 06h-09h fill the legacy base address; byte 06h gives bits 7-1 only.
// - Bytes 0Ah-0Dh fill all 32 system control bits, low byte first.
// - Bytes 0Eh-11h fill routing; byte 11h bits 3-0 give bits 27-24.
// - Byte 12h bits 7 and 6 load the retry status bits 7 and 6.
// - Byte 13h bit 7 loads card control bit 7 only.
// - Byte 14h bits 6 and 3-0 load device control bits alike.
// - Byte 15h bits 7 and 4-0 load diagnostic bits alike.
// - Byte 16h bit 7 loads power management capability bit 15.
// - Byte 17h loads the whole legacy socket identity/revision byte.
// - Byte 18h bit 3 loads socket force event bit 27.
// - The EEPROM is addressed as slave 1010000b.
// - Software access is four byte registers at B0h-B3h.
// - Data byte supplies write data and captures read data.
// - Index byte is sent as word address, but not in quick commands.
// - Writing the target select register starts a transaction.
// - Control/status reports read valid, busy, error and holds protocol select.
// - Only the reset-time loader issues the multi-byte EEPROM read.
// - A missing acknowledge sets the error status bit.
// - SCL runs near 100 kHz during transfers and is released when idle.
// - Byte write: start, address+0, index, data MSB first, acks, stop.
module secl_loader import secl_pkg::*; #(
	parameter int QTR_CYC = QTR_CYC_DEF
) (
	// Host clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Link clock
	input wire logic link_clk,
	// Configuration byte port
	input wire logic [7:0] cfg_addr,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] cfg_rdata,
	// Serial bus presence strap
	input wire logic bus_present,
	// Two-wire pins
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Loaded defaults
	output logic ld_apply,
	output logic [15:0] ld_command,
	output logic [15:0] ld_subsys_vendor,
	output logic [15:0] ld_subsys_id,
	output logic [31:0] ld_legacy_base_address,
	output logic [31:0] ld_sys_ctrl,
	output logic [27:0] ld_mfunc_routing,
	output logic [7:0] ld_retry_status,
	output logic ld_card_ctrl_b7,
	output logic [7:0] ld_dev_ctrl,
	output logic [7:0] ld_diag,
	output logic ld_pm_cap_b15,
	output logic [7:0] ld_legacy_socket_regs_id,
	output logic ld_force_b27
);
	if (QTR_CYC < 2 || QTR_CYC > 63) begin : g_bad_qtr
		$error("QTR_CYC must lie in 2..63");
	end

	localparam logic [5:0] QTR_LOAD = 6'(QTR_CYC - 1);

	// Host domain state
	secl_sys_st_e sst;
	logic [1:0] det_cnt;
	logic [1:0] pres_sync;
	logic [7:0] data_byte;
	logic [7:0] index_byte;
	logic [7:0] target_sel;
	logic proto_sel;
	logic rd_valid;
	logic err_flag;
	logic bus_present_flag;
	logic cmd_init;
	logic req_tgl;
	logic [2:0] done_sync;
	logic done_evt;
	logic det_now;
	logic sw_start;
	logic ctrl_wr;

	// Link domain state
	logic [1:0] lrst_q;
	logic lrst;
	logic [2:0] req_sync;
	logic req_evt;
	logic [1:0] sda_sync;
	logic [1:0] scl_sync;
	secl_link_st_e lst;
	secl_stage_e stage;
	logic [1:0] q;
	logic [5:0] qcnt;
	logic hold;
	logic step;
	logic [3:0] bitn;
	logic [7:0] shreg;
	logic samp;
	logic rx_mode;
	logic last_rd;
	logic l_init;
	logic [4:0] rcnt;
	logic nack;
	logic done_tgl;
	logic [7:0] rx_byte;
	logic [7:0] ee_byte [INIT_LEN];
	logic [6:0] l_addr;
	logic l_quick;
	logic byte_end;
	logic next_scl_oe;
	logic next_sda_oe;

	// ---------------- Host domain ----------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pres_sync <= 2'b00;
			done_sync <= 3'b000;
		end else begin
			pres_sync <= {pres_sync[0], bus_present};
			done_sync <= {done_sync[1:0], done_tgl};
		end
	end

	assign done_evt = done_sync[2] ^ done_sync[1];
	assign det_now = (sst == S_WAIT) && (det_cnt == DET_WAIT);
	// Writes are refused while a transfer runs so the link sees frozen operands
	assign sw_start = cfg_wr && (cfg_addr == SB_TARGET_OFS) && (sst == S_IDLE);
	assign ctrl_wr = cfg_wr && (cfg_addr == SB_CTRL_OFS);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sst <= S_WAIT;
			det_cnt <= 2'h0;
			cmd_init <= 1'b0;
			req_tgl <= 1'b0;
		end else begin
			unique case (sst)
				S_WAIT: begin
					det_cnt <= det_cnt + 2'h1;
					if (det_now) begin
						if (pres_sync[1]) begin
							cmd_init <= 1'b1;
							req_tgl <= ~req_tgl;
							sst <= S_BUSY;
						end else begin
							sst <= S_IDLE;
						end
					end
				end
				S_IDLE: begin
					if (sw_start) begin
						cmd_init <= 1'b0;
						req_tgl <= ~req_tgl;
						sst <= S_BUSY;
					end
				end
				S_BUSY: begin
					if (done_evt) begin
						sst <= S_IDLE;
					end
				end
			endcase
		end
	end

	// Software registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			data_byte <= 8'h00;
			index_byte <= 8'h00;
			target_sel <= 8'h00;
			proto_sel <= 1'b0;
		end else begin
			if (cfg_wr && cfg_addr == SB_DATA_OFS && sst != S_BUSY) begin
				data_byte <= cfg_wdata;
			end else if (done_evt && !cmd_init && target_sel[TS_RW] && !proto_sel && !nack) begin
				data_byte <= rx_byte;
			end
			if (cfg_wr && cfg_addr == SB_INDEX_OFS && sst != S_BUSY) begin
				index_byte <= cfg_wdata;
			end
			if (sw_start) begin
				target_sel <= cfg_wdata;
			end
			if (ctrl_wr && sst != S_BUSY) begin
				proto_sel <= cfg_wdata[CS_PROTO];
			end
		end
	end

	// Status flags; a hardware set wins over a write-one clear in the same cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rd_valid <= 1'b0;
			err_flag <= 1'b0;
			bus_present_flag <= 1'b0;
		end else begin
			if (done_evt && !cmd_init && target_sel[TS_RW] && !proto_sel && !nack) begin
				rd_valid <= 1'b1;
			end else if (sw_start) begin
				rd_valid <= 1'b0;
			end
			if (done_evt && nack) begin
				err_flag <= 1'b1;
			end else if (ctrl_wr && cfg_wdata[CS_ERROR]) begin
				err_flag <= 1'b0;
			end
			if (det_now && pres_sync[1]) begin
				bus_present_flag <= 1'b1;
			end else if (ctrl_wr && cfg_wdata[CS_DETECT]) begin
				bus_present_flag <= 1'b0;
			end
		end
	end

	// Read data follows the address one cycle later; unmapped offsets read zero
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfg_rdata <= 8'h00;
		end else begin
			unique case (cfg_addr)
				SB_DATA_OFS: cfg_rdata <= data_byte;
				SB_INDEX_OFS: cfg_rdata <= index_byte;
				SB_TARGET_OFS: cfg_rdata <= target_sel;
				SB_CTRL_OFS: cfg_rdata <= {2'b00, sst == S_BUSY, 1'b0, bus_present_flag, err_flag,
					proto_sel, rd_valid};
				default: cfg_rdata <= 8'h00;
			endcase
		end
	end

	// Defaults are handed out only when the flag byte reads exactly 01h
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ld_apply <= 1'b0;
			ld_command <= 16'h0000;
			ld_subsys_vendor <= 16'h0000;
			ld_subsys_id <= 16'h0000;
			ld_legacy_base_address <= 32'h0000_0000;
			ld_sys_ctrl <= 32'h0000_0000;
			ld_mfunc_routing <= 28'h000_0000;
			ld_retry_status <= 8'h00;
			ld_card_ctrl_b7 <= 1'b0;
			ld_dev_ctrl <= 8'h00;
			ld_diag <= 8'h00;
			ld_pm_cap_b15 <= 1'b0;
			ld_legacy_socket_regs_id <= 8'h00;
			ld_force_b27 <= 1'b0;
		end else begin
			ld_apply <= 1'b0;
			if (done_evt && cmd_init && !nack && ee_byte[EE_FLAG] == LOAD_YES) begin
				ld_apply <= 1'b1;
				ld_command <= {7'h00, ee_byte[EE_CMD][SRC_B7], 1'b0, ee_byte[EE_CMD][6:5], 2'b00,
					ee_byte[EE_CMD][2:0]};
				ld_subsys_vendor <= {ee_byte[EE_SSVID + 1], ee_byte[EE_SSVID]};
				ld_subsys_id <= {ee_byte[EE_SSID + 1], ee_byte[EE_SSID]};
				ld_legacy_base_address <= {ee_byte[EE_LEGACY_BASE + 3], ee_byte[EE_LEGACY_BASE + 2],
					ee_byte[EE_LEGACY_BASE + 1], ee_byte[EE_LEGACY_BASE][7:1], 1'b0};
				ld_sys_ctrl <= {ee_byte[EE_SYSCTL + 3], ee_byte[EE_SYSCTL + 2], ee_byte[EE_SYSCTL + 1],
					ee_byte[EE_SYSCTL]};
				ld_mfunc_routing <= {ee_byte[EE_MFUNC + 3][3:0], ee_byte[EE_MFUNC + 2], ee_byte[EE_MFUNC + 1],
					ee_byte[EE_MFUNC]};
				ld_retry_status <= ee_byte[EE_RETRY] & MASK_RETRY;
				ld_card_ctrl_b7 <= ee_byte[EE_CARD][SRC_B7];
				ld_dev_ctrl <= ee_byte[EE_DEVCTL] & MASK_DEVCTL;
				ld_diag <= ee_byte[EE_DIAG] & MASK_DIAG;
				ld_pm_cap_b15 <= ee_byte[EE_PMCAP][SRC_B7];
				ld_legacy_socket_regs_id <= ee_byte[EE_SOCKID];
				ld_force_b27 <= ee_byte[EE_FORCE][SRC_FORCE];
			end
		end
	end

	// ---------------- Link domain ----------------
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			lrst_q <= 2'b11;
		end else begin
			lrst_q <= {lrst_q[0], 1'b0};
		end
	end
	assign lrst = lrst_q[1];

	always_ff @(posedge link_clk or posedge lrst) begin
		if (lrst) begin
			req_sync <= 3'b000;
			sda_sync <= 2'b11;
			scl_sync <= 2'b11;
		end else begin
			req_sync <= {req_sync[1:0], req_tgl};
			sda_sync <= {sda_sync[0], sda_in};
			scl_sync <= {scl_sync[0], scl_in};
		end
	end

	assign req_evt = req_sync[2] ^ req_sync[1];
	// A slave holding SCL low stretches the current quarter
	assign hold = (lst != L_IDLE) && !scl_oe && !scl_sync[1];
	assign step = (qcnt == 6'h00) && !hold;
	assign l_addr = l_init ? EE_ADDR : target_sel[7:1];
	assign l_quick = !l_init && proto_sel;
	assign byte_end = (lst == L_BIT) && step && (q == 2'h3) && (bitn == 4'h8);

	always_ff @(posedge link_clk or posedge lrst) begin
		if (lrst) begin
			qcnt <= QTR_LOAD;
			q <= 2'h0;
		end else if (lst == L_IDLE) begin
			qcnt <= QTR_LOAD;
			q <= 2'h0;
		end else if (step) begin
			qcnt <= QTR_LOAD;
			q <= q + 2'h1;
		end else if (qcnt != 6'h00) begin
			qcnt <= qcnt - 6'h01;
		end
	end

	// Byte sequencer
	always_ff @(posedge link_clk or posedge lrst) begin
		if (lrst) begin
			lst <= L_IDLE;
			stage <= G_ADDR;
			bitn <= 4'h0;
			shreg <= 8'h00;
			samp <= 1'b1;
			rx_mode <= 1'b0;
			last_rd <= 1'b0;
			l_init <= 1'b0;
			rcnt <= 5'h00;
			nack <= 1'b0;
			done_tgl <= 1'b0;
		end else begin
			unique case (lst)
				L_IDLE: begin
					if (req_evt) begin
						lst <= L_START;
						stage <= G_ADDR;
						l_init <= cmd_init;
						nack <= 1'b0;
						rx_mode <= 1'b0;
					end
				end
				L_START: begin
					if (step && q == 2'h3) begin
						lst <= L_BIT;
						bitn <= 4'h0;
						rx_mode <= 1'b0;
						shreg <= {l_addr, (stage == G_RADDR) || (l_quick && target_sel[TS_RW])};
					end
				end
				L_BIT: begin
					if (step && q == 2'h2) begin
						samp <= sda_sync[1];
					end
					if (step && q == 2'h3 && bitn != 4'h8) begin
						shreg <= {shreg[6:0], samp};
						bitn <= bitn + 4'h1;
					end
					if (byte_end) begin
						bitn <= 4'h0;
						if (!rx_mode && samp) begin
							nack <= 1'b1;
							lst <= L_STOP;
						end else begin
							unique case (stage)
								G_ADDR: begin
									if (l_quick) begin
										lst <= L_STOP;
									end else begin
										shreg <= l_init ? EE_FIRST_WORD : index_byte;
										stage <= G_INDEX;
									end
								end
								G_INDEX: begin
									if (!l_init && !target_sel[TS_RW]) begin
										shreg <= data_byte;
										stage <= G_DATA;
									end else begin
										lst <= L_START;
										stage <= G_RADDR;
									end
								end
								G_DATA: begin
									lst <= L_STOP;
								end
								G_RADDR: begin
									rx_mode <= 1'b1;
									stage <= G_RDATA;
									rcnt <= 5'h00;
									last_rd <= !l_init;
								end
								G_RDATA: begin
									if (last_rd) begin
										lst <= L_STOP;
									end else begin
										rcnt <= rcnt + 5'h01;
										last_rd <= (rcnt + 5'h01) == INIT_LAST;
									end
								end
								default: begin
									lst <= L_STOP;
								end
							endcase
						end
					end
				end
				L_STOP: begin
					if (step && q == 2'h3) begin
						lst <= L_IDLE;
						done_tgl <= ~done_tgl;
					end
				end
			endcase
		end
	end

	// Received bytes; a blank EEPROM reads as all ones
	always_ff @(posedge link_clk or posedge lrst) begin
		if (lrst) begin
			rx_byte <= 8'h00;
			for (int i = 0; i < INIT_LEN; i++) begin
				ee_byte[i] <= LOAD_NO;
			end
		end else if (byte_end && rx_mode && stage == G_RDATA) begin
			if (l_init) begin
				ee_byte[rcnt] <= shreg;
			end else begin
				rx_byte <= shreg;
			end
		end
	end

	// Pin levels per quarter; enable high pulls the open-drain line low
	always_comb begin
		next_scl_oe = 1'b0;
		next_sda_oe = 1'b0;
		unique case (lst)
			L_IDLE: begin
				next_scl_oe = 1'b0;
				next_sda_oe = 1'b0;
			end
			L_START: begin
				next_scl_oe = (q == 2'h0) || (q == 2'h3);
				next_sda_oe = (q == 2'h2) || (q == 2'h3);
			end
			L_BIT: begin
				next_scl_oe = (q == 2'h0) || (q == 2'h3);
				if (bitn != 4'h8) begin
					next_sda_oe = !rx_mode && !shreg[7];
				end else begin
					next_sda_oe = rx_mode && !last_rd;
				end
			end
			L_STOP: begin
				next_scl_oe = (q == 2'h0);
				next_sda_oe = (q == 2'h0) || (q == 2'h1);
			end
		endcase
	end

	always_ff @(posedge link_clk or posedge lrst) begin
		if (lrst) begin
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			scl_oe <= next_scl_oe;
			sda_oe <= next_sda_oe;
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end
	end

	// ---------------- Checks ----------------
	busy_start_a: assert property (@(posedge sys_clk) disable iff (rst)
		sw_start |=> (sst == S_BUSY) && target_sel == $past(cfg_wdata))
		else $error("target write did not start a busy transfer");
	load_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
		ld_apply |-> ee_byte[EE_FLAG] == LOAD_YES && $past(cmd_init) && !nack)
		else $error("defaults applied without a 01h flag");
	cmd_map_a: assert property (@(posedge sys_clk) disable iff (rst)
		ld_apply |-> ld_command[8] == ee_byte[EE_CMD][7] && ld_command[7] == 1'b0 &&
			ld_command[1:0] == ee_byte[EE_CMD][1:0])
		else $error("command bits mapped wrongly");
	legacy_base_a: assert property (@(posedge sys_clk) disable iff (rst)
		ld_apply |-> ld_legacy_base_address[0] == 1'b0 &&
			ld_legacy_base_address[31:24] == ee_byte[EE_LEGACY_BASE + 3])
		else $error("legacy base address mapped wrongly");
	nack_err_a: assert property (@(posedge sys_clk) disable iff (rst)
		(done_evt && nack) |=> err_flag ##1 (sst == S_IDLE || sst == S_BUSY))
		else $error("missing acknowledge not reported");
	no_sw_init_a: assert property (@(posedge sys_clk) disable iff (rst)
		($rose(cmd_init)) |-> $past(sst) == S_WAIT)
		else $error("multi-byte load issued outside reset");
	scl_idle_a: assert property (@(posedge link_clk) disable iff (lrst)
		(lst == L_IDLE) [*2] |-> !scl_oe && !sda_oe)
		else $error("bus not released while idle");
	scl_steady_a: assert property (@(posedge link_clk) disable iff (lrst)
		(lst != L_IDLE && qcnt != 6'h00 && qcnt != QTR_LOAD) |=> $stable(scl_oe))
		else $error("SCL moved inside a quarter");
	ee_addr_a: assert property (@(posedge link_clk) disable iff (lrst)
		(lst == L_BIT && l_init && stage == G_ADDR && bitn == 4'h0) |-> shreg == {EE_ADDR, 1'b0})
		else $error("EEPROM addressed wrongly");
	busy_span_a: assert property (@(posedge sys_clk) disable iff (rst)
		(sst == S_BUSY && !done_evt) |=> sst == S_BUSY)
		else $error("busy dropped before stop");

	init_apply_c: cover property (@(posedge sys_clk) disable iff (rst) ld_apply);
	sw_write_c: cover property (@(posedge sys_clk) disable iff (rst)
		done_evt && !cmd_init && !target_sel[TS_RW] && !nack);
	sw_read_c: cover property (@(posedge sys_clk) disable iff (rst) $rose(rd_valid));
	nack_c: cover property (@(posedge sys_clk) disable iff (rst) $rose(err_flag));
endmodule : secl_loader

/* File: design/secl_pkg.sv */
// Constants and types shared by the serial EEPROM configuration loader
package secl_pkg;
	// Configuration-space byte offsets of the software serial-bus registers
	localparam logic [7:0] SB_DATA_OFS = 8'hb0;
	localparam logic [7:0] SB_INDEX_OFS = 8'hb1;
	localparam logic [7:0] SB_TARGET_OFS = 8'hb2;
	localparam logic [7:0] SB_CTRL_OFS = 8'hb3;
	// Control/status field positions
	localparam int CS_RDVALID = 0;
	localparam int CS_PROTO = 1;
	localparam int CS_ERROR = 2;
	localparam int CS_DETECT = 3;
	localparam int CS_BUSY = 5;
	// Target-select field positions
	localparam int TS_RW = 0;
	// EEPROM slave address and load flag values
	localparam logic [6:0] EE_ADDR = 7'h50;
	localparam logic [7:0] EE_FIRST_WORD = 8'h00;
	localparam logic [7:0] LOAD_YES = 8'h01;
	localparam logic [7:0] LOAD_NO = 8'hff;
	// EEPROM byte map
	localparam int INIT_LEN = 25;
	localparam logic [4:0] INIT_LAST = 5'h18;
	localparam int EE_FLAG = 0;
	localparam int EE_CMD = 1;
	localparam int EE_SSVID = 2;
	localparam int EE_SSID = 4;
	localparam int EE_LEGACY_BASE = 6;
	localparam int EE_SYSCTL = 10;
	localparam int EE_MFUNC = 14;
	localparam int EE_RETRY = 18;
	localparam int EE_CARD = 19;
	localparam int EE_DEVCTL = 20;
	localparam int EE_DIAG = 21;
	localparam int EE_PMCAP = 22;
	localparam int EE_SOCKID = 23;
	localparam int EE_FORCE = 24;
	// Bit masks and source bit positions of partially loaded fields
	localparam logic [7:0] MASK_RETRY = 8'hc0;
	localparam logic [7:0] MASK_DEVCTL = 8'h4f;
	localparam logic [7:0] MASK_DIAG = 8'h9f;
	localparam int SRC_B7 = 7;
	localparam int SRC_FORCE = 3;
	// Timing: SCL period and link clock period in ns, quarter-bit count rounded up
	localparam int SCL_PERIOD_NS = 10000;
	localparam int LINK_PERIOD_NS = 80;
	localparam int QTR_CYC_DEF = (SCL_PERIOD_NS + 4 * LINK_PERIOD_NS - 1) / (4 * LINK_PERIOD_NS);
	// Host-side wait for the presence strap to settle after reset
	localparam logic [1:0] DET_WAIT = 2'h3;

	typedef enum logic [1:0] {
		S_WAIT = 2'b00,
		S_IDLE = 2'b01,
		S_BUSY = 2'b10
	} secl_sys_st_e;

	typedef enum logic [1:0] {
		L_IDLE = 2'b00,
		L_START = 2'b01,
		L_BIT = 2'b10,
		L_STOP = 2'b11
	} secl_link_st_e;

	typedef enum logic [2:0] {
		G_ADDR = 3'b000,
		G_INDEX = 3'b001,
		G_DATA = 3'b010,
		G_RADDR = 3'b011,
		G_RDATA = 3'b100
	} secl_stage_e;
endpackage : secl_pkg

/* File: dv/secl_eeprom_model.sv */
// Behavioural serial EEPROM slave on the two-wire bus
module secl_eeprom_model (
	// Board-level lines
	input wire logic scl,
	input wire logic sda,
	// High while the model pulls SDA low
	output logic sda_pull
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [256];
	logic [7:0] rx, tx, ptr;
	int st = 0;
	int n = 0;
	initial sda_pull = 0;
	// Start or repeated start reopens the address phase
	always @(negedge sda) if (scl) begin
		st = 1;
		n = 0;
		sda_pull = 0;
	end
	always @(posedge sda) if (scl) begin
		st = 0;
		sda_pull = 0;
	end
	// Master NACK on a read byte ends the burst
	always @(posedge scl) if (st != 0) begin
		if (n < 8) rx = {rx[6:0], sda};
		else if (st == 4 && sda) st = 5;
		n = n + 1;
	end
	// SDA only moves while SCL is low, so no false start or stop
	always @(negedge scl) if (st != 0) begin
		if (n == 8) begin
			sda_pull = (st == 1 && rx[7:1] == 7'h50) || st == 2 || st == 3;
			if (st == 1) st = !sda_pull ? 5 : rx[0] ? 4 : 2;
			else if (st == 2) begin
				ptr = rx;
				st = 3;
			end else if (st == 3) begin
				mem[ptr] = rx;
				ptr = ptr + 1;
			end
		end else begin
			if (n == 9) begin
				n = 0;
				if (st == 4) begin
					tx = mem[ptr];
					ptr = ptr + 1;
				end
			end
			sda_pull = st == 4 && !tx[7 - n];
		end
	end
endmodule : secl_eeprom_model

/* File: dv/secl_loader_tb.sv */
// Self-checking bench for the serial EEPROM configuration loader
module secl_loader_tb import secl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk, link_clk, rst, cfg_wr, bus_present, ld;
	logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, ld_retry_status, ld_dev_ctrl, ld_diag, ld_legacy_socket_regs_id;
	logic scl_out, scl_oe, sda_out, sda_oe, sda_pull, ld_apply, ld_card_ctrl_b7, ld_pm_cap_b15, ld_force_b27;
	logic [15:0] ld_command, ld_subsys_vendor, ld_subsys_id;
	logic [31:0] ld_legacy_base_address, ld_sys_ctrl;
	logic [27:0] ld_mfunc_routing;
	// Pull-ups on both lines
	wire logic scl = !scl_oe;
	wire logic sda = !(sda_oe || sda_pull);
	logic [7:0] img [256];
	logic [7:0] v, idx, dat;
	int fails = 0;
	int n_checks = 0;
	int n_apply = 0;
	secl_loader #(.QTR_CYC(4)) secl_loader_inst (.sys_clk, .rst, .link_clk, .cfg_addr, .cfg_wr, .cfg_wdata,
		.cfg_rdata, .bus_present, .scl_in(scl), .scl_out, .scl_oe, .sda_in(sda), .sda_out, .sda_oe, .ld_apply,
		.ld_command, .ld_subsys_vendor, .ld_subsys_id, .ld_legacy_base_address, .ld_sys_ctrl, .ld_mfunc_routing,
		.ld_retry_status, .ld_card_ctrl_b7, .ld_dev_ctrl, .ld_diag, .ld_pm_cap_b15, .ld_legacy_socket_regs_id,
		.ld_force_b27);
	secl_eeprom_model secl_eeprom_model_inst (.scl(scl), .sda(sda), .sda_pull(sda_pull));
	initial begin
		sys_clk = 0;
		forever #50 sys_clk = ~sys_clk;
	end
	initial begin
		link_clk = 0;
		#17;
		forever #40 link_clk = ~link_clk;
	end
	always @(posedge sys_clk) if (ld_apply === 1'b1) n_apply++;
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		#5;
		cfg_addr = a;
		cfg_wdata = d;
		cfg_wr = 1;
		@(posedge sys_clk);
		#5;
		cfg_wr = 0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		#5;
		cfg_addr = a;
		@(posedge sys_clk);
		#5;
		d = cfg_rdata;
	endtask : rd
	// Polls busy under a bound so a hung engine cannot stall the run
	task automatic wait_idle();
		int k = 0;
		repeat (8) @(posedge sys_clk);
		do begin
			rd(SB_CTRL_OFS, v);
			k++;
		end while (v[CS_BUSY] !== 1'b0 && k < 20000);
		chk("idle", k < 20000, 1);
	endtask : wait_idle
	task automatic boot(input logic [7:0] flag, input logic pres);
		for (int i = 0; i < 256; i++) secl_eeprom_model_inst.mem[i] = (i == 0) ? flag : img[i];
		bus_present = pres;
		@(posedge sys_clk);
		#5;
		rst = 1;
		repeat (16) @(posedge sys_clk);
		#5;
		n_apply = 0;
		rst = 0;
		wait_idle();
		ld = flag == LOAD_YES && pres;
		chk("apply count", n_apply, ld);
		chk("detect", v[CS_DETECT], pres);
		chk("command", ld_command, ld ? {7'h0, img[1][7], 1'b0, img[1][6:5], 2'h0, img[1][2:0]} : 0);
		chk("ssvid", ld_subsys_vendor, ld ? {img[3], img[2]} : 0);
		chk("ssid", ld_subsys_id, ld ? {img[5], img[4]} : 0);
		chk("legacy base", ld_legacy_base_address, ld ? {img[9], img[8], img[7], img[6][7:1], 1'b0} : 0);
		chk("sysctl", ld_sys_ctrl, ld ? {img[13], img[12], img[11], img[10]} : 0);
		chk("mfunc", ld_mfunc_routing, ld ? {img[17][3:0], img[16], img[15], img[14]} : 0);
		chk("retry", ld_retry_status, ld ? img[18] & 8'hc0 : 0);
		chk("card", ld_card_ctrl_b7, ld ? img[19][7] : 0);
		chk("devctl", ld_dev_ctrl, ld ? img[20] & 8'h4f : 0);
		chk("diag", ld_diag, ld ? img[21] & 8'h9f : 0);
		chk("pmcap", ld_pm_cap_b15, ld ? img[22][7] : 0);
		chk("sockid", ld_legacy_socket_regs_id, ld ? img[23] : 0);
		chk("force", ld_force_b27, ld ? img[24][3] : 0);
		chk("flag untouched", secl_eeprom_model_inst.mem[0], flag);
	endtask : boot
	task automatic print_verdict();
		if (fails == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : print_verdict
	initial begin
		#8000000;
		fails++;
		print_verdict();
	end
	initial begin
		rst = 1;
		cfg_wr = 0;
		cfg_addr = 0;
		cfg_wdata = 0;
		bus_present = 1;
		v = $urandom(32'hd6ee);
		for (int i = 0; i < 256; i++) img[i] = $urandom;
		boot(LOAD_YES, 1);
		for (int t = 0; t < 4; t++) begin
			idx = $urandom;
			dat = $urandom;
			wr(SB_DATA_OFS, dat);
			wr(SB_INDEX_OFS, idx);
			wr(SB_TARGET_OFS, {EE_ADDR, 1'b0});
			rd(SB_CTRL_OFS, v);
			chk("busy", v[CS_BUSY], 1);
			wait_idle();
			img[idx] = dat;
			chk("eeprom byte", secl_eeprom_model_inst.mem[idx], img[idx]);
			wr(SB_DATA_OFS, ~dat);
			wr(SB_TARGET_OFS, {EE_ADDR, 1'b1});
			// Lands while busy, so it must be dropped
			wr(SB_INDEX_OFS, ~idx);
			wait_idle();
			chk("status", v & 8'h25, 8'h01);
			rd(SB_DATA_OFS, v);
			chk("read data", v, img[idx]);
			rd(SB_INDEX_OFS, v);
			chk("index", v, idx);
		end
		wr(SB_TARGET_OFS, {EE_ADDR ^ 7'h01, 1'b0});
		wait_idle();
		chk("nack error", v[CS_ERROR], 1);
		wr(SB_CTRL_OFS, 8'h0e);
		wr(SB_TARGET_OFS, {EE_ADDR, 1'b0});
		wait_idle();
		chk("quick status", v & 8'h2f, 8'h02);
		wr(SB_CTRL_OFS, 8'h00);
		rd(8'hb4, v);
		chk("unmapped", v, 0);
		chk("scl idle", scl_oe, 0);
		chk("sda idle", sda_oe, 0);
		chk("pin levels", {scl_out, sda_out}, 0);
		boot(LOAD_NO, 1);
		dat = $urandom | 8'h02;
		boot(dat, 1);
		boot(LOAD_YES, 0);
		print_verdict();
	end
endmodule : secl_loader_tb
